// *** design/ralu_top.sv ***
// Registered cascadable 16-bit ALU with AXI4-Lite configuration registers
//
// Behaviour
// - Two 16-bit operand registers, one shared clock.
// - Each operand register loads only on its enable.
// - Input bypass feeds pins; registers keep loading.
// - Result register loads only on its enable.
// - Result pins three-stated by output enable.
// - Result bypass shows combinational ALU; register keeps loading.
// - Bypasses active high; both give pure combinational ALU unless feedback is selected.
// - Bit generate is AND, propagate is OR.
// - Running group propagate, generate and internal carries.
// - Carry-out, overflow, inverted group propagate equations.
// - Subtract forms complement A or B for flags.
// - Operand selects steer zero, operand or feedback.
// - Feedback always from result register, bypass regardless.
// - Three select bits encode eight functions.
// - Zero flag when all result bits zero.
// - Cascade flags valid only for arithmetic functions.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "ralu_consts.svh"

module ralu_top
    import ralu_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Operand buses and load strobes
    input  wire logic [15:0] operand_a_in,
    input  wire logic [15:0] operand_b_in,
    input  wire logic        operand_a_load_enable,
    input  wire logic        operand_b_load_enable,
    input  wire logic        result_load_enable,
    // Result bus, three-state
    output logic [15:0]      result_out,
    output logic [15:0]      result_oe,
    // Cascade status
    output logic             zero_flag,
    output logic             carry_out,
    output logic             overflow_flag,
    output logic             group_propagate_n,
    output logic             group_generate_n
);

    // ======================================================================
    // Configuration register and AXI4-Lite slave state
    // ======================================================================
    logic [8:0]  config_q, config_d;
    logic        aw_got_q, aw_got_d;
    logic [7:0]  aw_addr_q, aw_addr_d;
    logic        w_got_q, w_got_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0]  w_strb_q, w_strb_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;

    ralu_fn_t   function_select;
    logic       operand_a_select;
    logic       operand_b_select;
    logic       carry_in;
    logic       input_register_bypass;
    logic       result_register_bypass;
    logic       output_enable;

    assign function_select =
        ralu_fn_t'(config_q[`RALU_CFG_FS_MSB:`RALU_CFG_FS_LSB]);
    assign operand_a_select       = config_q[`RALU_CFG_ASEL_BIT];
    assign operand_b_select       = config_q[`RALU_CFG_BSEL_BIT];
    assign carry_in               = config_q[`RALU_CFG_CIN_BIT];
    assign input_register_bypass  = config_q[`RALU_CFG_INBYP_BIT];
    assign result_register_bypass = config_q[`RALU_CFG_RESBYP_BIT];
    assign output_enable          = config_q[`RALU_CFG_OE_BIT];

    // ======================================================================
    // Datapath registers
    // ======================================================================
    ralu_word_t op_a_q, op_a_d;
    ralu_word_t op_b_q, op_b_d;
    ralu_word_t res_q, res_d;
    ralu_word_t src_a;
    ralu_word_t src_b;

    ralu_alu_if alu_bus ();

    ralu_core u_core (
        .bus (alu_bus.core)
    );

    always_comb begin
        op_a_d = operand_a_load_enable ? operand_a_in : op_a_q;
        op_b_d = operand_b_load_enable ? operand_b_in : op_b_q;
        res_d  = result_load_enable ? alu_bus.alu_f : res_q;
    end

    // No reset here: contents stay unknown until the first load
    always_ff @(posedge aclk) begin
        op_a_q <= op_a_d;
        op_b_q <= op_b_d;
        res_q  <= res_d;
    end

    // Registers keep loading while bypassed; only the source changes
    assign src_a = input_register_bypass ? operand_a_in : op_a_q;
    assign src_b = input_register_bypass ? operand_b_in : op_b_q;

    always_comb begin
        case ({operand_b_select, operand_a_select})
            2'b00: begin
                alu_bus.alu_b = res_q;
                alu_bus.alu_a = src_a;
            end
            2'b01: begin
                alu_bus.alu_b = 16'h0000;
                alu_bus.alu_a = src_a;
            end
            2'b10: begin
                alu_bus.alu_b = src_b;
                alu_bus.alu_a = 16'h0000;
            end
            default: begin
                alu_bus.alu_b = src_b;
                alu_bus.alu_a = src_a;
            end
        endcase
    end

    assign alu_bus.fn  = function_select;
    assign alu_bus.cin = carry_in;

    // Result pins follow the ALU with no pipeline stage when bypassed
    assign result_out = result_register_bypass ? alu_bus.alu_f : res_q;
    assign result_oe  = {16{output_enable}};

    // Flags are combinational, not taken from the result register
    assign zero_flag         = alu_bus.zero;
    assign carry_out         = alu_bus.cout;
    assign overflow_flag     = alu_bus.overflow;
    assign group_propagate_n = alu_bus.prop_n;
    assign group_generate_n  = alu_bus.gen_n;

    // ======================================================================
    // AXI4-Lite write path
    // ======================================================================
    logic        do_write;
    logic [31:0] cfg_word;

    assign do_write = aw_got_q && w_got_q && !bvalid_q;

    always_comb begin
        aw_got_d  = aw_got_q;
        aw_addr_d = aw_addr_q;
        w_got_d   = w_got_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        config_d  = config_q;
        cfg_word  = {23'h000000, config_q};
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_d  = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_d  = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (do_write) begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            if (aw_addr_q == `RALU_OFS_CONFIG) begin
                if (w_strb_q[0]) begin
                    cfg_word[7:0] = w_data_q[7:0];
                end
                if (w_strb_q[1]) begin
                    cfg_word[15:8] = w_data_q[15:8];
                end
                config_d = cfg_word[8:0];
                bresp_d  = `RALU_RESP_OKAY;
            end else begin
                bresp_d = `RALU_RESP_SLVERR;
            end
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    // ======================================================================
    // AXI4-Lite read path
    // ======================================================================
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h00000000;
        status_word[`RALU_ST_ZERO_BIT]   = alu_bus.zero;
        status_word[`RALU_ST_COUT_BIT]   = alu_bus.cout;
        status_word[`RALU_ST_OVERFLOW_BIT] = alu_bus.overflow;
        status_word[`RALU_ST_PROP_N_BIT] = alu_bus.prop_n;
        status_word[`RALU_ST_GEN_N_BIT]  = alu_bus.gen_n;
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = `RALU_RESP_OKAY;
            case (s_axi_araddr)
                `RALU_OFS_CONFIG:    rdata_d = {23'h000000, config_q};
                `RALU_OFS_STATUS:    rdata_d = status_word;
                `RALU_OFS_RESULT:    rdata_d = {16'h0000, res_q};
                `RALU_OFS_OPERAND_A: rdata_d = {16'h0000, op_a_q};
                `RALU_OFS_OPERAND_B: rdata_d = {16'h0000, op_b_q};
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = `RALU_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // ======================================================================
    // Bus state registers
    // ======================================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_q  <= `RALU_CFG_RESET;
            aw_got_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_got_q   <= 1'b0;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RALU_RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= `RALU_RESP_OKAY;
        end else begin
            config_q  <= config_d;
            aw_got_q  <= aw_got_d;
            aw_addr_q <= aw_addr_d;
            w_got_q   <= w_got_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // One outstanding write: ready drops while an item is held
    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready  = !w_got_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

endmodule

`default_nettype wire

// *** design/ralu_consts.svh ***
// Offsets, field positions and reset values of the registered ALU block
`ifndef RALU_CONSTS_SVH
`define RALU_CONSTS_SVH

`define RALU_WIDTH          16
`define RALU_MSB            15
`define RALU_FS_WIDTH       3

`define RALU_ADDR_WIDTH     8
`define RALU_OFS_CONFIG     8'h00
`define RALU_OFS_STATUS     8'h04
`define RALU_OFS_RESULT     8'h08
`define RALU_OFS_OPERAND_A  8'h0c
`define RALU_OFS_OPERAND_B  8'h10

`define RALU_CFG_FS_LSB     0
`define RALU_CFG_FS_MSB     2
`define RALU_CFG_ASEL_BIT   3
`define RALU_CFG_BSEL_BIT   4
`define RALU_CFG_CIN_BIT    5
`define RALU_CFG_INBYP_BIT  6
`define RALU_CFG_RESBYP_BIT 7
`define RALU_CFG_OE_BIT     8
`define RALU_CFG_WIDTH      9
`define RALU_CFG_RESET      9'h000

`define RALU_ST_ZERO_BIT    0
`define RALU_ST_COUT_BIT    1
`define RALU_ST_OVERFLOW_BIT 2
`define RALU_ST_PROP_N_BIT  3
`define RALU_ST_GEN_N_BIT   4

`define RALU_RESP_OKAY      2'b00
`define RALU_RESP_SLVERR    2'b10

`endif

// *** design/ralu_pkg.sv ***
// Types shared by the registered ALU block
package ralu_pkg;

    typedef enum logic [2:0] {
        RALU_FN_CLEAR    = 3'b000,
        RALU_FN_NOTA_ADD = 3'b001,
        RALU_FN_NOTB_ADD = 3'b010,
        RALU_FN_ADD      = 3'b011,
        RALU_FN_XOR      = 3'b100,
        RALU_FN_OR       = 3'b101,
        RALU_FN_AND      = 3'b110,
        RALU_FN_PRESET   = 3'b111
    } ralu_fn_t;

    typedef logic [15:0] ralu_word_t;

endpackage

// *** design/ralu_alu_if.sv ***
// Connection between the register datapath and the combinational ALU core
`timescale 1ns/1ns
`default_nettype none

interface ralu_alu_if;
    import ralu_pkg::*;
    ralu_word_t alu_a;
    ralu_word_t alu_b;
    ralu_fn_t   fn;
    logic       cin;
    ralu_word_t alu_f;
    logic       zero;
    logic       cout;
    logic       overflow;
    logic       prop_n;
    logic       gen_n;

    modport core (input alu_a, alu_b, fn, cin,
                  output alu_f, zero, cout, overflow, prop_n, gen_n);
    modport user (output alu_a, alu_b, fn, cin,
                  input alu_f, zero, cout, overflow, prop_n, gen_n);
endinterface

`default_nettype wire

// *** design/ralu_core.sv ***
// Combinational 16-bit ALU with lookahead carry and cascade status
`timescale 1ns/1ns
`default_nettype none
`include "ralu_consts.svh"

module ralu_core
    import ralu_pkg::*;
(
    // ALU operands, function and results
    ralu_alu_if.core bus
);

    ralu_word_t a_eff;
    ralu_word_t b_eff;
    ralu_word_t bit_g;
    ralu_word_t bit_p;
    ralu_word_t grp_g;
    ralu_word_t grp_p;
    ralu_word_t carry;
    ralu_word_t sum;

    // Subtract forms run the same chain on complemented operands
    assign a_eff = (bus.fn == RALU_FN_NOTA_ADD) ? ~bus.alu_a : bus.alu_a;
    assign b_eff = (bus.fn == RALU_FN_NOTB_ADD) ? ~bus.alu_b : bus.alu_b;

    assign bit_g = a_eff & b_eff;
    assign bit_p = a_eff | b_eff;

    assign grp_g[0] = bit_g[0];
    assign grp_p[0] = bit_p[0];
    assign carry[0] = bus.cin;

    genvar i;
    generate
        for (i = 1; i < `RALU_WIDTH; i = i + 1) begin : g_chain
            assign grp_p[i] = bit_p[i] & grp_p[i-1];
            assign grp_g[i] = bit_g[i] | (bit_p[i] & grp_g[i-1]);
            assign carry[i] = grp_g[i-1] | (grp_p[i-1] & bus.cin);
        end
    endgenerate

    assign sum = a_eff ^ b_eff ^ carry;

    // Flags follow the arithmetic chain in every mode; only valid for adds
    assign bus.cout   = grp_g[`RALU_MSB] | (grp_p[`RALU_MSB] & bus.cin);
    assign bus.overflow = carry[`RALU_MSB] ^ bus.cout;
    assign bus.prop_n = ~grp_p[`RALU_MSB];
    assign bus.gen_n  = ~grp_g[`RALU_MSB];

    always_comb begin
        case (bus.fn)
            RALU_FN_CLEAR:    bus.alu_f = 16'h0000;
            RALU_FN_NOTA_ADD: bus.alu_f = sum;
            RALU_FN_NOTB_ADD: bus.alu_f = sum;
            RALU_FN_ADD:      bus.alu_f = sum;
            RALU_FN_XOR:      bus.alu_f = bus.alu_a ^ bus.alu_b;
            RALU_FN_OR:       bus.alu_f = bus.alu_a | bus.alu_b;
            RALU_FN_AND:      bus.alu_f = bus.alu_a & bus.alu_b;
            RALU_FN_PRESET:   bus.alu_f = 16'hffff;
            default:          bus.alu_f = 16'h0000;
        endcase
    end

    assign bus.zero = (bus.alu_f == 16'h0000);

endmodule

`default_nettype wire

// *** test/ralu_monitor.sv ***
// Port-level checker for the registered ALU top, bound into it
`timescale 1ns/1ns
`default_nettype none
`include "ralu_consts.svh"

module ralu_monitor (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_bvalid,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Datapath
    input wire logic        result_load_enable,
    input wire logic [15:0] result_out,
    input wire logic [15:0] result_oe,
    input wire logic        zero_flag
);
    // ==========
    // Shadow of output enable and result bypass, one cycle late
    logic       aw0_q;
    logic       oe_q;
    logic       byp_q;
    logic       bv_q;
    logic [1:0] wd_q;

    always_ff @(posedge aclk) begin
        bv_q <= s_axi_bvalid;
        if (!aresetn) begin
            oe_q  <= 1'b0;
            byp_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready)
                aw0_q <= (s_axi_awaddr == `RALU_OFS_CONFIG);
            if (s_axi_wvalid && s_axi_wready)
                wd_q <= s_axi_wdata[8:7];
            if (s_axi_bvalid && !bv_q && aw0_q
                && s_axi_bresp == `RALU_RESP_OKAY)
                {oe_q, byp_q} <= wd_q;
        end
    end

    // ==========
    // Properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // Shadow lags the write by one cycle, so skip the bvalid cycle
    property p_oe_cfg;
        !s_axi_bvalid |-> result_oe == {16{oe_q}};
    endproperty
    property p_oe_rst;
        $rose(aresetn) |-> result_oe == 16'h0;
    endproperty
    property p_res_hold;
        !result_load_enable && !byp_q && !s_axi_bvalid
            |=> s_axi_bvalid || $stable(result_out);
    endproperty
    property p_zero;
        byp_q && !s_axi_bvalid |-> zero_flag == (result_out == 16'h0);
    endproperty
    property p_rd_lat;
        s_rd_taken |=> s_axi_rvalid;
    endproperty
    property p_rd_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    property p_rd_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    property p_wr_resp;
        s_wr_taken |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_wr_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty

    a_oe_cfg: assert property (p_oe_cfg)
        else $error("result_oe differs from output enable");
    a_oe_rst: assert property (p_oe_rst)
        else $error("result_oe not off after reset");
    a_res_hold: assert property (p_res_hold)
        else $error("result changed without load enable");
    a_zero: assert property (p_zero)
        else $error("zero flag disagrees with result");
    a_rd_lat: assert property (p_rd_lat)
        else $error("read data late");
    a_rd_done: assert property (p_rd_done)
        else $error("rvalid stays after handshake");
    a_rd_block: assert property (p_rd_block)
        else $error("arready while rvalid");
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response late");
    a_wr_block: assert property (p_wr_block)
        else $error("write ready while bvalid");
endmodule

bind ralu_top ralu_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .result_load_enable,
    .result_out, .result_oe, .zero_flag);
`default_nettype wire

// *** test/ralu_bus_peer.sv ***
// Shared result bus with a second driver and a pull-up
`timescale 1ns/1ns
`default_nettype none

module ralu_bus_peer (
    // Device side
    input wire logic [15:0] result_out,
    input wire logic [15:0] result_oe,
    // Second driver
    input wire logic        peer_en,
    input wire logic [15:0] peer_val,
    // Resolved bus
    output logic [15:0]     bus_lvl
);
    // Peer yields per bit wherever the device drives
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (result_oe[i]) bus_lvl[i] = result_out[i];
            else if (peer_en) bus_lvl[i] = peer_val[i];
            else bus_lvl[i] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** test/test_registered_cascadable_alu16.sv ***
// Self-checking bench for the registered ALU top
`timescale 1ns/1ns
`default_nettype none
`include "ralu_consts.svh"

module test_registered_cascadable_alu16;
    logic        aclk, aresetn, peer_en, look;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, zero_flag, carry_out;
    logic        overflow_flag, group_propagate_n, group_generate_n;
    logic        operand_a_load_enable, operand_b_load_enable;
    logic        result_load_enable;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] operand_a_in, operand_b_in, result_out, result_oe;
    logic [15:0] peer_val, bus_lvl, ra, rb, rf, a;
    logic [8:0]  cfg;
    logic [33:0] dq[$], dm[$], rq[$], bq[$];
    int          seed, n_mismatch, n_compared, cyc;

    ralu_top DUT (.*);
    ralu_bus_peer u_peer (.result_out, .result_oe, .peer_en, .peer_val,
                          .bus_lvl);

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // ==========
    // Reference and checking
    function automatic logic [20:0] ref_alu(input logic [2:0] fn,
        input logic [15:0] a, b, input logic cin);
        logic [15:0] x, y, f, c;
        logic [16:0] s, g;
        x = (fn == 3'b001) ? ~a : a;
        y = (fn == 3'b010) ? ~b : b;
        s = {1'b0, x} + {1'b0, y} + 17'(cin);
        g = {1'b0, x} + {1'b0, y};
        c = {1'b0, x[14:0]} + {1'b0, y[14:0]} + 16'(cin);
        case (fn)
            3'b000:  f = 16'h0;
            3'b100:  f = a ^ b;
            3'b101:  f = a | b;
            3'b110:  f = a & b;
            3'b111:  f = 16'hffff;
            default: f = s[15:0];
        endcase
        return {~g[16], ~&(x | y), f == 16'h0, s[16], c[15] ^ s[16], f};
    endfunction

    task check(input string nm, input logic [33:0] e, m, g);
        n_compared++;
        if (((g ^ e) & m) !== 34'h0) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e & m, g & m);
        end
    endtask

    always @(negedge aclk) begin
        if (look)
            check("datapath", dq.pop_front(), dm.pop_front(),
                  {13'h0, group_generate_n, group_propagate_n, zero_flag,
                   carry_out, overflow_flag, bus_lvl});
        if (s_axi_rvalid && s_axi_rready)
            check("rdata", rq.pop_front(), 34'h3ffffffff,
                  {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            check("bresp", bq.pop_front(), 34'h3, {32'h0, s_axi_bresp});
    end

    // ==========
    // Bus and datapath drivers
    task axw(input logic [7:0] ad, input logic [31:0] d,
             input logic [1:0] er);
        logic ta, tw, b;
        bq.push_back({32'h0, er});
        s_axi_awaddr  <= ad;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge aclk);
            b = s_axi_bvalid;
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task axr(input logic [7:0] ad, input logic [33:0] e);
        logic ta, r;
        rq.push_back(e);
        s_axi_araddr  <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        r = 1'b0;
        while (!r) begin
            @(negedge aclk);
            r = s_axi_rvalid;
            ta = s_axi_arvalid && s_axi_arready;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Fields: oe, result bypass, input bypass, cin, B select, A select, fn
    task setcfg(input logic [8:0] c);
        axw(`RALU_OFS_CONFIG, {23'h0, c}, `RALU_RESP_OKAY);
        cfg = c;
    endtask

    task step(input logic [15:0] pa, pb, input logic ea, eb, ef);
        logic [15:0] av, bv;
        logic [20:0] al;
        av = cfg[6] ? pa : ra;
        bv = cfg[6] ? pb : rb;
        al = ref_alu(cfg[2:0], (cfg[4:3] == 2'b10) ? 16'h0 : av,
                     cfg[4] ? bv : (cfg[3] ? 16'h0 : rf), cfg[5]);
        dq.push_back({13'h0, al[20:16], cfg[8] ? (cfg[7] ? al[15:0] : rf)
                      : (peer_en ? peer_val : 16'hffff)});
        dm.push_back((cfg[2:0] inside {3'd1, 3'd2, 3'd3}) ? 34'h1fffff
                     : 34'h04ffff);
        operand_a_in          <= pa;
        operand_b_in          <= pb;
        operand_a_load_enable <= ea;
        operand_b_load_enable <= eb;
        result_load_enable    <= ef;
        look                  <= 1'b1;
        @(posedge aclk);
        operand_a_load_enable <= 1'b0;
        operand_b_load_enable <= 1'b0;
        result_load_enable    <= 1'b0;
        look                  <= 1'b0;
        if (ea) ra = pa;
        if (eb) rb = pb;
        if (ef) rf = al[15:0];
        @(posedge aclk);
    endtask

    task report_and_stop;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop;
        end
    end

    // ==========
    // Scenarios
    initial begin
        seed = 32'h91be;
        {n_mismatch, n_compared, cyc} = '0;
        {ra, rb, rf, cfg, peer_val, peer_en, look} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata  = '0;
        s_axi_wstrb  = 4'hf;
        operand_a_in = '0;
        operand_b_in = '0;
        aresetn      = 1'b0;
        // Load zeros everywhere while held in reset
        {operand_a_load_enable, operand_b_load_enable} = 2'b11;
        result_load_enable = 1'b1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        operand_a_load_enable <= 1'b0;
        operand_b_load_enable <= 1'b0;
        result_load_enable    <= 1'b0;
        @(posedge aclk);
        axr(`RALU_OFS_CONFIG, 34'h0);
        axr(8'h40, {`RALU_RESP_SLVERR, 32'h0});
        axw(`RALU_OFS_STATUS, 32'h1ff, `RALU_RESP_SLVERR);
        for (int i = 0; i < 64; i++) begin
            setcfg({3'b111, 1'($random(seed)), 2'b11, 3'(i)});
            a = (i < 8) ? 16'h7fff : ((i < 16) ? 16'hffff : 16'($random(seed)));
            step(a, (i < 16) ? 16'h0001 : 16'($random(seed)), 0, 0, 0);
        end
        setcfg(9'h11b);
        a = 16'($random(seed));
        step(a, a, 1, 0, 0);
        a = 16'($random(seed));
        step(a, a, 0, 1, 0);
        step(16'h0, 16'h0, 0, 0, 1);
        step(16'h1234, 16'h4321, 0, 0, 0);
        axr(`RALU_OFS_RESULT, {18'h0, rf});
        setcfg(9'h10b);
        step(16'h0, 16'h0, 0, 0, 1);
        setcfg(9'h103);
        for (int k = 0; k < 3; k++) begin
            step(16'($random(seed)), 16'h0, 1, 0, 0);
            step(16'h0, 16'h0, 0, 0, 1);
        end
        setcfg(9'h183);
        step(16'h0, 16'h0, 0, 0, 1);
        step(16'h0, 16'h0, 0, 0, 0);
        setcfg(9'h103);
        step(16'h0, 16'h0, 0, 0, 0);
        setcfg(9'h113);
        step(16'h0, 16'h0, 0, 0, 1);
        setcfg(9'h15b);
        step(16'($random(seed)), 16'($random(seed)), 1, 0, 0);
        setcfg(9'h11b);
        step(16'h0, 16'h0, 0, 0, 0);
        axr(`RALU_OFS_OPERAND_A, {18'h0, ra});
        setcfg(9'h13a);
        step(16'h0, 16'h0, 0, 0, 1);
        setcfg(9'h118);
        step(16'h0, 16'h0, 0, 0, 1);
        setcfg(9'h01b);
        axr(`RALU_OFS_CONFIG, {25'h0, 9'h01b});
        step(16'h0, 16'h0, 0, 0, 0);
        peer_en  = 1'b1;
        peer_val = 16'($random(seed));
        step(16'h0, 16'h0, 0, 0, 0);
        peer_en = 1'b0;
        report_and_stop;
    end
endmodule
`default_nettype wire
